// ==== include/ppp_pkg.sv ====
// Constants shared by the port power policing block and its current-limit accumulator.
// Assumes one 20 MHz clock and a plain strobe register port with 8-bit data.
// Functional notes
// - Over-current accumulator rises by one on every over-current evaluation.
// - Each evaluation without over-current lowers the accumulator by one sixteenth.
// - Persistent over-current raises a current-limit fault and removes port power.
// - A very large over-current switches the output transistor off at once.
// - Time spent in the current-limited state is bounded to protect the transistor.
// - The current-limit template follows the class of the attached powered device.
// - Each current-limit fault sets its pair set's flag in the fault register.
// - Granted class comes from budget, pair-count mode, topology and requested class.
// - Granted class becomes pair-set limits; four-pair ports also get the combined limit.
// - Each pair set is policed alone; four-pair ports also police the summed power.
// - Enforced overload thresholds sit slightly above the programmed limits.
// - Pair-set overloads set pair-set faults; combined overloads set the combined fault.
// - Probe-power behaviour applies only to single-signature four-pair ports.
// - Automatic mode watches the first long finger and flags the acknowledgement.
// - Detected devices are measured at power good; limits are power plus margin.
// - Manual completion writes both measured power fields and clears both request bits in the same cycle.
package ppp_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned EVAL_PERIOD_NS = 50000;
  localparam int unsigned EVAL_CYCLES    = (EVAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LIMIT_TIME_MS  = 60;
  localparam int unsigned LIMIT_EVALS    = LIMIT_TIME_MS * 1000000 / EVAL_PERIOD_NS;
  localparam int unsigned ACC_W          = 16;
  localparam int unsigned ACC_STEP       = 16;
  localparam logic [15:0] ACC_UP         = 16'h0010;
  localparam logic [15:0] ACC_THRESHOLD  = 16'(LIMIT_EVALS * ACC_STEP);
  localparam int unsigned SETTLE_US      = 1000;
  localparam int unsigned SETTLE_CYCLES  = SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SET_W          = 15;

  // Register offsets.
  localparam logic [7:0] ADDR_FAULT     = 8'h00;
  localparam logic [7:0] ADDR_CONTROL   = 8'h01;
  localparam logic [7:0] ADDR_BUDGET    = 8'h02;
  localparam logic [7:0] ADDR_MODE      = 8'h03;
  localparam logic [7:0] ADDR_LIMIT0    = 8'h04;
  localparam logic [7:0] ADDR_LIMIT1    = 8'h05;
  localparam logic [7:0] ADDR_LIMIT_4P  = 8'h06;
  localparam logic [7:0] ADDR_PROBE0    = 8'h07;
  localparam logic [7:0] ADDR_PROBE1    = 8'h08;
  localparam logic [7:0] ADDR_CLASS     = 8'h09;
  localparam logic [7:0] ADDR_STATUS    = 8'h0a;

  // Fault register fields: current limit [1:0], pair-set overload [3:2], combined [4].
  localparam int unsigned F_CURRENT_LIMIT    = 0;
  localparam int unsigned F_OVL2P   = 2;
  localparam int unsigned F_OVL4P   = 4;
  // Control register fields.
  localparam int unsigned C_AUTO    = 0;
  localparam int unsigned C_MANUAL  = 1;
  // Mode register fields.
  localparam int unsigned M_FOURPAIR = 0;

  localparam logic [7:0] RST_BUDGET  = 8'h44;
  localparam logic [7:0] RST_CONTROL = 8'h01;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] AUTO_MARGIN = 8'h04;
  localparam int unsigned POLICE_MARGIN_SHIFT = 4;
  localparam logic [3:0] MAX_CLASS   = 4'h8;

  typedef enum logic [2:0] {
    PPP_MAN_IDLE   = 3'b001,
    PPP_MAN_SETTLE = 3'b010,
    PPP_MAN_STORE  = 3'b100
  } ppp_man_state_t;
endpackage

// ==== verilog/ppp_current_limit_acc.sv ====
// Current-limit accumulator and short-circuit cutoff for one pair set.
// Assumes over-current and short-circuit flags are synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module ppp_current_limit_acc
  import ppp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic eval,
  input  wire logic powered,
  input  wire logic over_current,
  input  wire logic short_circuit,
  output logic      fault
);
  logic [ACC_W-1:0] acc;

  // Fixed point with four fraction bits: one whole step up, one sixteenth down.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
    end else if (ce) begin
      if (!powered) begin
        acc <= '0;
      end else if (eval && over_current) begin
        acc <= (acc > ACC_THRESHOLD) ? acc : ACC_W'(acc + ACC_UP);
      end else if (eval && acc != '0) begin
        acc <= ACC_W'(acc - 1'b1);
      end
    end
  end

  // Reaching the threshold bounds how long the transistor stays limited.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault <= 1'b0;
    end else if (ce) begin
      fault <= powered && (short_circuit || acc >= ACC_THRESHOLD);
    end
  end
endmodule
`default_nettype wire

// ==== verilog/ppp_port_police.sv ====
// Port power policing for one four-pair port made of two pair sets.
// Assumes a power sequencer drives FET_REQUEST and the class-done and power-good levels.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ppp_port_police
  import ppp_pkg::*;
#(
  parameter int unsigned SETTLE_COUNT = SETTLE_CYCLES
)
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       CE,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [1:0] FET_REQUEST,
  input  wire logic [1:0] POWER_GOOD,
  input  wire logic       CLASS_DONE,
  input  wire logic [3:0] PD_REQUESTED_CLASS0,
  input  wire logic [3:0] PD_REQUESTED_CLASS1,
  input  wire logic       SINGLE_SIGNATURE,
  input  wire logic [1:0] FIRST_FINGER,
  input  wire logic [1:0] PD_ACK,
  input  wire logic [1:0] OVER_CURRENT,
  input  wire logic [1:0] SHORT_CIRCUIT,
  input  wire logic [7:0] PAIR_POWER0,
  input  wire logic [7:0] PAIR_POWER1,
  output logic      [1:0] POWER_ENABLE,
  output logic      [3:0] CURRENT_LIMIT_SEL0,
  output logic      [3:0] CURRENT_LIMIT_SEL1
);
  logic [4:0]  fault_reg;
  logic [2:0]  control;
  logic [7:0]  power_budget_setting;
  logic        pair_count_mode;
  logic [7:0]  limit [2];
  logic [7:0]  combined_power_limit;
  logic [7:0]  measured_probe_power [2];
  logic [3:0]  granted_class [2];
  logic [1:0]  auto_power_probe_detected;
  logic [1:0]  current_limit_hit;
  logic [1:0]  ovl2p_hit;
  logic        ovl4p_hit;
  logic [1:0]  latched_off;
  logic [1:0]  pg_q;
  logic [9:0]  eval_cnt;
  logic        eval;
  logic [SET_W-1:0] settle_cnt;
  ppp_man_state_t man_state;
  ppp_man_state_t next_man_state;
  logic [7:0]  pwr [2];
  logic [8:0]  pwr_sum;
  logic        probe_port;
  logic        wr_fault;
  logic        wr_control;
  logic        pg_rise;
  logic        man_store;

  // Class to minimum pair-set power in half-watt steps.
  function automatic logic [7:0] class_power(input logic [3:0] cls);
    case (cls)
      4'h1:    class_power = 8'h08;
      4'h2:    class_power = 8'h0e;
      4'h4:    class_power = 8'h3c;
      4'h5:    class_power = 8'h2d;
      4'h6:    class_power = 8'h3c;
      4'h7:    class_power = 8'h4b;
      4'h8:    class_power = 8'h5a;
      default: class_power = 8'h1f;
    endcase
  endfunction

  // Enforced threshold lies a sixteenth above the programmed value.
  function automatic logic [9:0] police_threshold(input logic [8:0] lim);
    police_threshold = {1'b0, lim} + {5'h00, lim[8:POLICE_MARGIN_SHIFT]};
  endfunction

  function automatic logic [7:0] sat_add(input logic [8:0] a);
    sat_add = a[8] ? 8'hff : a[7:0];
  endfunction

  function automatic logic [3:0] min_class(input logic [3:0] a, input logic [3:0] b);
    min_class = (a < b) ? a : b;
  endfunction

  assign pwr[0]     = PAIR_POWER0;
  assign pwr[1]     = PAIR_POWER1;
  assign pwr_sum    = {1'b0, PAIR_POWER0} + {1'b0, PAIR_POWER1};
  assign probe_port = pair_count_mode && SINGLE_SIGNATURE;
  assign wr_fault   = WR && ADDR == ADDR_FAULT;
  assign wr_control = WR && ADDR == ADDR_CONTROL;
  assign pg_rise    = (&POWER_GOOD) && !(&pg_q);
  assign man_store  = man_state == PPP_MAN_STORE;

  // Evaluation tick for the accumulators.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      eval_cnt <= '0;
      eval     <= 1'b0;
    end else if (CE) begin
      eval     <= eval_cnt == 10'(EVAL_CYCLES - 1);
      eval_cnt <= (eval_cnt == 10'(EVAL_CYCLES - 1)) ? '0 : 10'(eval_cnt + 1'b1);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_acc
      ppp_current_limit_acc u_acc (
        .clk           (CLK),
        .rst_b         (RST_B),
        .ce            (CE),
        .eval          (eval),
        .powered       (POWER_ENABLE[g]),
        .over_current  (OVER_CURRENT[g]),
        .short_circuit (SHORT_CIRCUIT[g]),
        .fault         (current_limit_hit[g])
      );
      assign ovl2p_hit[g] = POWER_GOOD[g] &&
        {2'b00, pwr[g]} > police_threshold({1'b0, limit[g]});
    end
  endgenerate

  assign ovl4p_hit = pair_count_mode && (&POWER_GOOD) &&
    {1'b0, pwr_sum} > police_threshold({1'b0, combined_power_limit});

  // Faults latch the transistor off until the sequencer withdraws its request.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      latched_off  <= 2'b00;
      POWER_ENABLE <= 2'b00;
    end else if (CE) begin
      for (int i = 0; i < 2; i++) begin
        if (!FET_REQUEST[i]) begin
          latched_off[i]  <= 1'b0;
          POWER_ENABLE[i] <= 1'b0;
        end else if (current_limit_hit[i] || ovl2p_hit[i] || ovl4p_hit) begin
          latched_off[i]  <= 1'b1;
          POWER_ENABLE[i] <= 1'b0;
        end else begin
          POWER_ENABLE[i] <= !latched_off[i];
        end
      end
    end
  end

  // Sticky fault flags: write one to clear, a new fault wins over the clear.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_reg <= '0;
    end else if (CE) begin
      for (int i = 0; i < 2; i++) begin
        fault_reg[F_CURRENT_LIMIT+i] <= current_limit_hit[i] ||
          (fault_reg[F_CURRENT_LIMIT+i] && !(wr_fault && WDATA[F_CURRENT_LIMIT+i]));
        fault_reg[F_OVL2P+i] <= ovl2p_hit[i] ||
          (fault_reg[F_OVL2P+i] && !(wr_fault && WDATA[F_OVL2P+i]));
      end
      fault_reg[F_OVL4P] <= ovl4p_hit ||
        (fault_reg[F_OVL4P] && !(wr_fault && WDATA[F_OVL4P]));
    end
  end

  // Granted class per pair set, and the current-limit template that follows it.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      granted_class[0]   <= '0;
      granted_class[1]   <= '0;
      CURRENT_LIMIT_SEL0 <= '0;
      CURRENT_LIMIT_SEL1 <= '0;
    end else if (CE) begin
      if (CLASS_DONE) begin
        if (probe_port) begin
          granted_class[0] <= min_class(PD_REQUESTED_CLASS0,
                                        power_budget_setting[3:0]);
          granted_class[1] <= min_class(PD_REQUESTED_CLASS0,
                                        power_budget_setting[3:0]);
        end else begin
          granted_class[0] <= min_class(PD_REQUESTED_CLASS0,
                                        power_budget_setting[3:0]);
          granted_class[1] <= min_class(PD_REQUESTED_CLASS1,
                                        power_budget_setting[7:4]);
        end
      end
      CURRENT_LIMIT_SEL0 <= granted_class[0];
      CURRENT_LIMIT_SEL1 <= granted_class[1];
    end
  end

  // Acknowledgement seen during the first long finger marks a probe-capable device.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      auto_power_probe_detected <= 2'b00;
    end else if (CE) begin
      for (int i = 0; i < 2; i++) begin
        if (!FET_REQUEST[i] && !FIRST_FINGER[i]) begin
          auto_power_probe_detected[i] <= auto_power_probe_detected[i] && !CLASS_DONE;
        end else if (FIRST_FINGER[i] && PD_ACK[i] && control[C_AUTO] && probe_port) begin
          auto_power_probe_detected[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pg_q <= 2'b00;
    end else if (CE) begin
      pg_q <= POWER_GOOD;
    end
  end

  // Manual measurement sequence: settle, then store the powers and release the request in one cycle.
  always_comb begin
    next_man_state = man_state;
    case (man_state)
      PPP_MAN_IDLE: begin
        if (control[C_MANUAL+1 -: 2] == 2'b11 && probe_port && (&POWER_GOOD)) begin
          next_man_state = PPP_MAN_SETTLE;
        end
      end
      PPP_MAN_SETTLE: begin
        if (settle_cnt == SET_W'(SETTLE_COUNT - 1)) begin
          next_man_state = PPP_MAN_STORE;
        end
      end
      PPP_MAN_STORE: next_man_state = PPP_MAN_IDLE;
      default:       next_man_state = PPP_MAN_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      man_state  <= PPP_MAN_IDLE;
      settle_cnt <= '0;
    end else if (CE) begin
      man_state  <= next_man_state;
      settle_cnt <= (man_state == PPP_MAN_SETTLE) ? SET_W'(settle_cnt + 1'b1) : '0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      measured_probe_power[0] <= '0;
      measured_probe_power[1] <= '0;
    end else if (CE) begin
      if (man_store || (pg_rise && probe_port && (&auto_power_probe_detected))) begin
        measured_probe_power[0] <= PAIR_POWER0;
        measured_probe_power[1] <= PAIR_POWER1;
      end
    end
  end

  // Police limits: class values after class power-on, measured values at power good.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      limit[0]             <= '0;
      limit[1]             <= '0;
      combined_power_limit <= '0;
    end else if (CE) begin
      if (pg_rise && probe_port && (&auto_power_probe_detected)) begin
        limit[0] <= sat_add({1'b0, PAIR_POWER0} + {1'b0, AUTO_MARGIN});
        limit[1] <= sat_add({1'b0, PAIR_POWER1} + {1'b0, AUTO_MARGIN});
        combined_power_limit <= sat_add(pwr_sum + {1'b0, AUTO_MARGIN});
      end else if (CLASS_DONE) begin
        limit[0] <= class_power(granted_class[0]);
        limit[1] <= class_power(granted_class[1]);
        if (pair_count_mode) begin
          combined_power_limit <= sat_add({1'b0, class_power(granted_class[0])} +
                                          {1'b0, class_power(granted_class[1])});
        end
      end else if (WR) begin
        if (ADDR == ADDR_LIMIT0) limit[0] <= WDATA;
        if (ADDR == ADDR_LIMIT1) limit[1] <= WDATA;
        if (ADDR == ADDR_LIMIT_4P) combined_power_limit <= WDATA;
      end
    end
  end

  // Configuration written by software.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      power_budget_setting <= RST_BUDGET;
      pair_count_mode      <= RST_MODE[M_FOURPAIR];
    end else if (CE && WR) begin
      if (ADDR == ADDR_BUDGET) power_budget_setting <= WDATA;
      if (ADDR == ADDR_MODE) pair_count_mode <= WDATA[M_FOURPAIR];
    end
  end

  // Manual request bits are cleared by hardware in the same cycle that the results are stored.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      control <= RST_CONTROL[2:0];
    end else if (CE) begin
      if (man_store) begin
        control[C_MANUAL+1 -: 2] <= 2'b00;
      end else if (wr_control) begin
        control <= WDATA[2:0];
      end
    end
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= '0;
      if (RD) begin
        case (ADDR)
          ADDR_FAULT:    RDATA <= {3'b000, fault_reg};
          ADDR_CONTROL:  RDATA <= {5'b00000, control};
          ADDR_BUDGET:   RDATA <= power_budget_setting;
          ADDR_MODE:     RDATA <= {7'b0000000, pair_count_mode};
          ADDR_LIMIT0:   RDATA <= limit[0];
          ADDR_LIMIT1:   RDATA <= limit[1];
          ADDR_LIMIT_4P: RDATA <= combined_power_limit;
          ADDR_PROBE0:   RDATA <= measured_probe_power[0];
          ADDR_PROBE1:   RDATA <= measured_probe_power[1];
          ADDR_CLASS:    RDATA <= {granted_class[1], granted_class[0]};
          ADDR_STATUS:   RDATA <= {2'b00, latched_off, auto_power_probe_detected,
                                   POWER_ENABLE};
          default:       RDATA <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ppp_port_police_checker.sv ====
// Port-level assertions for the port power policing block.
// Assumes CE stays high during checks; bound to every instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module ppp_port_police_checker
  import ppp_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       CE,
  input wire logic [7:0] ADDR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [1:0] FET_REQUEST,
  input wire logic [1:0] SHORT_CIRCUIT,
  input wire logic [1:0] POWER_ENABLE,
  input wire logic [3:0] CURRENT_LIMIT_SEL0,
  input wire logic [3:0] CURRENT_LIMIT_SEL1
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_short0;
    CE && POWER_ENABLE[0] && SHORT_CIRCUIT[0];
  endsequence
  sequence s_short1;
    CE && POWER_ENABLE[1] && SHORT_CIRCUIT[1];
  endsequence

  property p_short0;
    s_short0 |-> ##[1:2] !POWER_ENABLE[0];
  endproperty
  property p_short1;
    s_short1 |-> ##[1:2] !POWER_ENABLE[1];
  endproperty
  property p_on_req;
    CE && $rose(FET_REQUEST[0]) && !SHORT_CIRCUIT[0] |=> POWER_ENABLE[0];
  endproperty
  property p_on_cause;
    $rose(POWER_ENABLE[0]) |-> $past(FET_REQUEST[0]) && !$past(FET_REQUEST[0], 2);
  endproperty
  property p_rdata_idle;
    CE && !RD |=> RDATA == 8'h00;
  endproperty
  property p_unmapped;
    CE && RD && ADDR > ADDR_STATUS |=> RDATA == 8'h00;
  endproperty
  property p_status_pe;
    CE && RD && ADDR == ADDR_STATUS |=> RDATA[1:0] == $past(POWER_ENABLE);
  endproperty
  property p_class_sel;
    CE && RD && ADDR == ADDR_CLASS |=> RDATA == {CURRENT_LIMIT_SEL1, CURRENT_LIMIT_SEL0};
  endproperty

  a_short0: assert property (p_short0)
    else $error("pair 0 stayed on after a short");
  a_short1: assert property (p_short1)
    else $error("pair 1 stayed on after a short");
  a_on_req: assert property (p_on_req)
    else $error("transistor did not follow a new request");
  a_on_cause: assert property (p_on_cause)
    else $error("transistor came back on without a fresh request");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  a_status_pe: assert property (p_status_pe)
    else $error("status enable bits differ from the enable outputs");
  a_class_sel: assert property (p_class_sel)
    else $error("template select differs from granted class");
endmodule

bind ppp_port_police ppp_port_police_checker i_chk (
  .CLK(CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
  .FET_REQUEST(FET_REQUEST), .SHORT_CIRCUIT(SHORT_CIRCUIT), .POWER_ENABLE(POWER_ENABLE),
  .CURRENT_LIMIT_SEL0(CURRENT_LIMIT_SEL0), .CURRENT_LIMIT_SEL1(CURRENT_LIMIT_SEL1)
);
`default_nettype wire

// ==== testbench/ppp_pd_model.sv ====
// Sequencer and powered device seen from the port: requests, power draw, faults.
// Assumes commands come from the bench; all outputs are registered on clk.
`timescale 1ns/1ps
`default_nettype none
module ppp_pd_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] power_enable,
  input  wire logic [1:0] fet_cmd,
  input  wire logic [7:0] draw0,
  input  wire logic [7:0] draw1,
  input  wire logic [1:0] oc_cmd,
  input  wire logic [1:0] sc_cmd,
  input  wire logic       capable,
  input  wire logic       finger,
  output logic      [1:0] fet_request,
  output logic      [1:0] power_good,
  output logic      [7:0] pair_power0,
  output logic      [7:0] pair_power1,
  output logic      [1:0] over_current,
  output logic      [1:0] short_circuit,
  output logic      [1:0] first_finger,
  output logic      [1:0] pd_ack
);
  // An unpowered pair set draws nothing and can show no current fault.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fet_request   <= 2'b00;
      power_good    <= 2'b00;
      pair_power0   <= 8'h00;
      pair_power1   <= 8'h00;
      over_current  <= 2'b00;
      short_circuit <= 2'b00;
      first_finger  <= 2'b00;
      pd_ack        <= 2'b00;
    end else begin
      fet_request   <= fet_cmd;
      power_good    <= power_enable;
      pair_power0   <= power_enable[0] ? draw0 : 8'h00;
      pair_power1   <= power_enable[1] ? draw1 : 8'h00;
      over_current  <= oc_cmd & power_enable;
      short_circuit <= sc_cmd & power_enable;
      first_finger  <= {2{finger}};
      pd_ack        <= {2{finger & capable}};
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the port power policing block.
// Assumes the bound checker and the powered device model beside the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ppp_pkg::*;
;
  logic       CLK = 1'b0;
  logic       RST_B = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       CE = 1'b1;
  logic       CLASS_DONE = 1'b0;
  logic       SINGLE_SIGNATURE = 1'b0;
  logic [3:0] PD_REQUESTED_CLASS0 = 4'h0;
  logic [3:0] PD_REQUESTED_CLASS1 = 4'h0;
  logic [1:0] fet_cmd = 2'b00;
  logic [7:0] draw0 = 8'h00;
  logic [7:0] draw1 = 8'h00;
  logic [1:0] oc_cmd = 2'b00;
  logic [1:0] sc_cmd = 2'b00;
  logic       capable = 1'b0;
  logic       finger = 1'b0;
  logic [7:0] RDATA;
  logic [1:0] FET_REQUEST, POWER_GOOD, FIRST_FINGER, PD_ACK, OVER_CURRENT, SHORT_CIRCUIT;
  logic [7:0] PAIR_POWER0, PAIR_POWER1;
  logic [1:0] POWER_ENABLE;
  logic [3:0] CURRENT_LIMIT_SEL0, CURRENT_LIMIT_SEL1;
  int         err_count = 0;
  int         n_compared = 0;
  logic [7:0] rst_exp [12] = '{8'h00, RST_CONTROL, RST_BUDGET, RST_MODE,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 CLK = ~CLK;

  ppp_port_police #(.SETTLE_COUNT(8)) i_dut (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .FET_REQUEST(FET_REQUEST), .POWER_GOOD(POWER_GOOD),
    .CLASS_DONE(CLASS_DONE), .PD_REQUESTED_CLASS0(PD_REQUESTED_CLASS0),
    .PD_REQUESTED_CLASS1(PD_REQUESTED_CLASS1), .SINGLE_SIGNATURE(SINGLE_SIGNATURE),
    .FIRST_FINGER(FIRST_FINGER), .PD_ACK(PD_ACK), .OVER_CURRENT(OVER_CURRENT),
    .SHORT_CIRCUIT(SHORT_CIRCUIT), .PAIR_POWER0(PAIR_POWER0), .PAIR_POWER1(PAIR_POWER1),
    .POWER_ENABLE(POWER_ENABLE), .CURRENT_LIMIT_SEL0(CURRENT_LIMIT_SEL0),
    .CURRENT_LIMIT_SEL1(CURRENT_LIMIT_SEL1)
  );

  ppp_pd_model i_pd (
    .clk(CLK), .rst_b(RST_B), .power_enable(POWER_ENABLE), .fet_cmd(fet_cmd),
    .draw0(draw0), .draw1(draw1), .oc_cmd(oc_cmd), .sc_cmd(sc_cmd), .capable(capable),
    .finger(finger), .fet_request(FET_REQUEST), .power_good(POWER_GOOD),
    .pair_power0(PAIR_POWER0), .pair_power1(PAIR_POWER1), .over_current(OVER_CURRENT),
    .short_circuit(SHORT_CIRCUIT), .first_finger(FIRST_FINGER), .pd_ack(PD_ACK)
  );

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp);
  endtask

  task automatic wait_pe(input int i, input logic v, input int n);
    for (int k = 0; k < n && POWER_ENABLE[i] !== v; k++) @(posedge CLK);
    #1;
    chk8({7'h00, POWER_ENABLE[i]}, {7'h00, v});
    if (POWER_ENABLE[i] !== v) test_done();
  endtask

  task automatic class_pulse();
    @(posedge CLK);
    CLASS_DONE <= 1'b1;
    @(posedge CLK);
    CLASS_DONE <= 1'b0;
  endtask

  task automatic grant(input logic [7:0] b, input logic [7:0] m, input logic ss,
                       input logic [3:0] r0, input logic [3:0] r1, input logic [7:0] e);
    wr(ADDR_BUDGET, b);
    wr(ADDR_MODE, m);
    SINGLE_SIGNATURE    <= ss;
    PD_REQUESTED_CLASS0 <= r0;
    PD_REQUESTED_CLASS1 <= r1;
    class_pulse();
    rc(ADDR_CLASS, e);
    chk8({CURRENT_LIMIT_SEL1, CURRENT_LIMIT_SEL0}, e);
  endtask

  initial begin
    logic [7:0] d;
    cyc(20);
    RST_B <= 1'b1;
    for (int k = 0; k < 12; k++) rc(8'(k), rst_exp[k]);
    // A write while the clock enable is low must leave the register untouched.
    @(posedge CLK);
    CE <= 1'b0;
    wr(ADDR_BUDGET, 8'h11);
    CE <= 1'b1;
    rc(ADDR_BUDGET, RST_BUDGET);
    wr(ADDR_CLASS, 8'hff);
    rc(ADDR_CLASS, 8'h00);
    wr(ADDR_PROBE0, 8'haa);
    rc(ADDR_PROBE0, 8'h00);
    wr(8'h20, 8'h5a);
    rc(8'h20, 8'h00);
    wr(ADDR_LIMIT_4P, 8'h5a);
    rc(ADDR_LIMIT_4P, 8'h5a);
    grant(8'h53, 8'h00, 1'b0, 4'h5, 4'h2, 8'h23);
    grant(8'h66, 8'h01, 1'b1, 4'h4, 4'h7, 8'h44);
    // Two-pair mode with generous limits, then a short on pair set 0.
    wr(ADDR_MODE, 8'h00);
    for (int k = 4; k < 7; k++) wr(8'(k), 8'hff);
    draw0   <= 8'h10;
    draw1   <= 8'h10;
    fet_cmd <= 2'b11;
    wait_pe(0, 1'b1, 5);
    wait_pe(1, 1'b1, 5);
    sc_cmd <= 2'b01;
    @(posedge CLK);
    sc_cmd <= 2'b00;
    wait_pe(0, 1'b0, 5);
    rc(ADDR_FAULT, 8'h01);
    cyc(20);
    rc(ADDR_STATUS, 8'h12);
    wr(ADDR_FAULT, 8'h01);
    rc(ADDR_FAULT, 8'h00);
    fet_cmd <= 2'b10;
    cyc(3);
    fet_cmd <= 2'b11;
    wait_pe(0, 1'b1, 6);
    // Pair-set limit at its boundary, with transient over-current on pair set 1.
    wr(ADDR_LIMIT0, 8'h20);
    draw0  <= 8'h22;
    oc_cmd <= 2'b10;
    cyc(3000);
    oc_cmd <= 2'b00;
    rc(ADDR_STATUS, 8'h03);
    rc(ADDR_FAULT, 8'h00);
    draw0 <= 8'h23;
    wait_pe(0, 1'b0, 2100);
    rc(ADDR_FAULT, 8'h04);
    chk8({7'h00, POWER_ENABLE[1]}, 8'h01);
    wr(ADDR_FAULT, 8'h04);
    fet_cmd <= 2'b00;
    cyc(3);
    // Combined limit: the sum crosses while each pair set stays legal.
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_LIMIT_4P, 8'h30);
    draw0   <= 8'h19;
    draw1   <= 8'h1a;
    fet_cmd <= 2'b11;
    wait_pe(1, 1'b1, 5);
    cyc(2100);
    rc(ADDR_STATUS, 8'h03);
    draw1 <= 8'h1b;
    wait_pe(0, 1'b0, 2100);
    wait_pe(1, 1'b0, 5);
    rc(ADDR_FAULT, 8'h10);
    wr(ADDR_FAULT, 8'h10);
    fet_cmd <= 2'b00;
    cyc(3);
    // Manual probe measurement on a single-signature four-pair port.
    wr(ADDR_LIMIT0, 8'hff);
    wr(ADDR_LIMIT_4P, 8'hff);
    draw0   <= 8'h31;
    draw1   <= 8'h42;
    fet_cmd <= 2'b11;
    wait_pe(1, 1'b1, 5);
    cyc(3);
    wr(ADDR_CONTROL, 8'h07);
    for (int k = 0; k < 50; k++) begin
      rd(ADDR_CONTROL, d);
      if (d[2:1] == 2'b00) break;
    end
    chk8(d, 8'h01);
    if (d[2:1] != 2'b00) test_done();
    rc(ADDR_PROBE0, 8'h31);
    rc(ADDR_PROBE1, 8'h42);
    wr(ADDR_LIMIT0, 8'h33);
    rc(ADDR_LIMIT0, 8'h33);
    fet_cmd <= 2'b00;
    cyc(3);
    // Automatic probe: acknowledgement in the first finger, then power good.
    capable <= 1'b1;
    finger  <= 1'b1;
    cyc(4);
    class_pulse();
    finger <= 1'b0;
    rc(ADDR_STATUS, 8'h0c);
    draw0   <= 8'h10;
    draw1   <= 8'h14;
    fet_cmd <= 2'b11;
    wait_pe(0, 1'b1, 5);
    cyc(6);
    rc(ADDR_LIMIT0, 8'h10 + AUTO_MARGIN);
    rc(ADDR_LIMIT1, 8'h14 + AUTO_MARGIN);
    test_done();
  end
endmodule
`default_nettype wire
